/* core/rtdad_pkg.sv */
// constants, types and helpers shared by both ends of the record link
package rtdad_pkg;
    // fixed opcodes
    localparam logic [7:0] OPC_NULL = 8'h00;
    localparam logic [7:0] OPC_TBL_WR = 8'hff;
    localparam logic [7:0] OPC_TBL_RD = 8'hfe;
    localparam logic [7:0] OPC_DIR_WR = 8'hfd;
    // payload lengths in bytes
    localparam logic [6:0] LEN_TBL_WR = 7'h04;
    localparam logic [6:0] LEN_TBL_RD = 7'h01;
    localparam logic [6:0] LEN_DIR_WR = 7'h18;
    localparam logic [6:0] LEN_STS_RSP = 7'h01;
    localparam logic [6:0] LEN_RD_RSP = 7'h04;
    localparam logic [6:0] LEN_HDR = 7'h03;
    localparam logic [6:0] LEN_PAY_MAX = 7'h52;
    // widths
    localparam int PAY_W = 656;
    localparam int KEY_W = 640;
    localparam int DATA_W = 80;
    localparam int CTX_W = 16;
    localparam int TX_W = 680;
    localparam int RSP_W = 56;
    localparam logic [9:0] CTX_BITS = 10'h010;
    localparam logic [9:0] PAY_BITS = 10'h290;
    localparam logic [6:0] ASSOC_NARROW = 7'h20;
    localparam logic [6:0] ASSOC_WIDE = 7'h40;
    localparam logic [2:0] CMP_OP_CODE = 3'h1;
    localparam logic [6:0] STS_ZERO = 7'h00;
    // payload field positions
    localparam int TW_ADDR_LSB = 24;
    localparam int TW_ZERO_LSB = 19;
    localparam int DW_ADDR_LSB = 160;

    // one opcode table entry
    typedef struct packed {
        logic [9:0] instr;
        logic ctx_mode;
        logic record_entry_valid;
        logic [6:0] record_length;
    } rtdad_entry_s;

    typedef enum logic [1:0] {
        TGT_REG = 2'b00,
        TGT_RULE_DB = 2'b01,
        TGT_ASSOC = 2'b10,
        TGT_BAD = 2'b11
    } rtdad_target_e;

    // 32-bit direct write address
    typedef struct packed {
        logic write_format_sel;
        logic entry_valid_bit;
        logic [2:0] zero;
        rtdad_target_e target;
        logic [1:0] rsvd;
        logic [22:0] loc;
    } rtdad_addr_s;

    // table entry mapping an opcode to a mode 0 compare
    function automatic rtdad_entry_s rtdad_cmp_entry(input logic [6:0] len,
                                                     input logic [6:0] logical_table_number);
        rtdad_entry_s e;
        e.instr = {CMP_OP_CODE, logical_table_number};
        e.ctx_mode = 1'b0;
        e.record_entry_valid = 1'b1;
        e.record_length = len;
        return e;
    endfunction : rtdad_cmp_entry
endpackage : rtdad_pkg

/* core/rtdad_link_if.sv */
// byte-wide record link between host and device
`timescale 1ns/100ps
interface rtdad_link_if;
    logic req_valid;
    logic [7:0] req_data;
    logic req_ready;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_ready;
    modport dev (input req_valid, input req_data, output req_ready,
                 output rsp_valid, output rsp_data, input rsp_ready);
    modport hst (output req_valid, output req_data, input req_ready,
                 input rsp_valid, input rsp_data, output rsp_ready);
endinterface : rtdad_link_if

/* core/rtdad_device.sv */
// device end: record decoder, opcode table, direct writes, status responses
//
// Contract
// - records: opcode, 16-bit sequence, then payload
// - response sequence equals request sequence
// - table write: opcode 255, address, entry
// - write responses carry status byte, error bit0
// - table read: opcode 254, one address byte
// - table read answer: status, zeros, entry
// - direct write: opcode 253, address, data, mask
// - address: format, valid, zeros, location
// - database: data/mask or X/Y by format
// - assoc array: 32 or 64 bits, low aligned
// - host sends format zero on register writes
// - host sets valid bit for database only
// - mask ignored for registers and assoc array
// - mode 0: whole payload is the key
// - mode 1: top 16 bits are context tag
// - host builds compare instruction from table number
// - entry: length, valid, mode, instruction fields
// - host waits for table write response
// - host increments request sequence numbers
`timescale 1ns/100ps
module rtdad_device
    import rtdad_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    rtdad_link_if.dev link,
    output logic key_valid,
    output logic [7:0] key_opcode,
    output logic [15:0] key_seq,
    output logic [9:0] key_instr,
    output logic key_ctx_present,
    output logic [CTX_W-1:0] key_ctx_tag,
    output logic [KEY_W-1:0] key_data,
    output logic dw_valid,
    output rtdad_target_e dw_target,
    output logic dw_fmt,
    output logic dw_entry_valid,
    output logic [22:0] dw_loc,
    output logic [DATA_W-1:0] dw_data,
    output logic [DATA_W-1:0] dw_mask
);
    typedef enum logic [2:0] {
        ST_OPC = 3'b000,
        ST_SEQ_HI = 3'b001,
        ST_SEQ_LO = 3'b011,
        ST_PAY = 3'b010,
        ST_EXEC = 3'b110,
        ST_RESP = 3'b111
    } rtdad_dstate_e;

    rtdad_dstate_e state_r;
    rtdad_entry_s table_r [256];
    logic [7:0] opc_r;
    logic [15:0] seq_r;
    logic [6:0] cnt_r;
    logic [PAY_W-1:0] pay_r;
    logic [RSP_W-1:0] rbuf_r;
    logic [6:0] rcnt_r;
    logic take;
    rtdad_entry_s ent;
    logic [6:0] plen;
    rtdad_addr_s daddr;
    logic dw_err;
    logic tw_err;
    logic [9:0] sh;
    logic [PAY_W-1:0] kmask;

    // fixed opcodes answered by the record layer itself
    function automatic logic rtdad_is_fixed(input logic [7:0] op);
        return (op == OPC_TBL_WR) || (op == OPC_TBL_RD) || (op == OPC_DIR_WR);
    endfunction : rtdad_is_fixed

    assign take = link.req_valid && link.req_ready;
    assign link.req_ready = (state_r == ST_OPC) || (state_r == ST_SEQ_HI)
                            || (state_r == ST_SEQ_LO) || (state_r == ST_PAY);
    assign link.rsp_valid = (state_r == ST_RESP);
    assign link.rsp_data = rbuf_r[RSP_W-1 -: 8];
    assign ent = table_r[opc_r];
    assign daddr = pay_r[DW_ADDR_LSB +: 32];
    // payload length per opcode; an invalid entry carries none
    always_comb begin
        unique case (opc_r)
            OPC_TBL_WR: plen = LEN_TBL_WR;
            OPC_TBL_RD: plen = LEN_TBL_RD;
            OPC_DIR_WR: plen = LEN_DIR_WR;
            default: plen = ent.record_entry_valid ? ent.record_length : 7'h00;
        endcase
    end
    // malformed direct write or table write
    assign dw_err = (daddr.zero != 3'h0) || (daddr.rsvd != 2'h0)
                    || (daddr.target == TGT_BAD);
    assign tw_err = (pay_r[TW_ZERO_LSB +: 5] != 5'h00);
    // mode 1 split point: bits below the context tag
    assign sh = {ent.record_length, 3'b000} - CTX_BITS;
    assign kmask = {PAY_W{1'b1}} >> (PAY_BITS - sh);

    // record parser: opcode, sequence, payload back to back
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_OPC;
            opc_r <= 8'h00;
            seq_r <= 16'h0000;
            cnt_r <= 7'h00;
            pay_r <= '0;
        end else begin
            unique case (state_r)
                ST_OPC: if (take && link.req_data != OPC_NULL) begin
                    opc_r <= link.req_data;
                    pay_r <= '0;
                    state_r <= ST_SEQ_HI;
                end
                ST_SEQ_HI: if (take) begin
                    seq_r[15:8] <= link.req_data;
                    state_r <= ST_SEQ_LO;
                end
                ST_SEQ_LO: if (take) begin
                    seq_r[7:0] <= link.req_data;
                    cnt_r <= plen;
                    state_r <= (plen == 7'h00) ? ST_EXEC : ST_PAY;
                end
                ST_PAY: if (take) begin
                    pay_r <= {pay_r[PAY_W-9:0], link.req_data};
                    cnt_r <= cnt_r - 7'h01;
                    if (cnt_r == 7'h01) begin
                        state_r <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    state_r <= (rtdad_is_fixed(opc_r) || !ent.record_entry_valid)
                               ? ST_RESP : ST_OPC;
                end
                ST_RESP: if (link.rsp_ready && rcnt_r == 7'h01) begin
                    state_r <= ST_OPC;
                end
                default: state_r <= ST_OPC; // unused codes recover to idle
            endcase
        end
    end

    // opcode table writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 256; i++) begin
                table_r[i] <= '0;
            end
        end else if (state_r == ST_EXEC && opc_r == OPC_TBL_WR && !tw_err) begin
            table_r[pay_r[TW_ADDR_LSB +: 8]] <= pay_r[18:0];
        end
    end

    // response builder and byte shifter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rbuf_r <= '0;
            rcnt_r <= 7'h00;
        end else if (state_r == ST_EXEC) begin
            if (opc_r == OPC_TBL_RD) begin
                rbuf_r <= {opc_r, seq_r, STS_ZERO, 1'b0, 5'h00,
                           table_r[pay_r[7:0]]};
                rcnt_r <= LEN_HDR + LEN_RD_RSP;
            end else begin
                rbuf_r <= {opc_r, seq_r, STS_ZERO,
                           (opc_r == OPC_TBL_WR) ? tw_err :
                           (opc_r == OPC_DIR_WR) ? dw_err : 1'b1, 24'h000000};
                rcnt_r <= LEN_HDR + LEN_STS_RSP;
            end
        end else if (state_r == ST_RESP && link.rsp_ready) begin
            rbuf_r <= {rbuf_r[RSP_W-9:0], 8'h00};
            rcnt_r <= rcnt_r - 7'h01;
        end
    end

    // key delivery to the core for valid table entries
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            key_valid <= 1'b0;
            key_opcode <= 8'h00;
            key_seq <= 16'h0000;
            key_instr <= 10'h000;
            key_ctx_present <= 1'b0;
            key_ctx_tag <= '0;
            key_data <= '0;
        end else begin
            key_valid <= (state_r == ST_EXEC) && !rtdad_is_fixed(opc_r)
                         && ent.record_entry_valid;
            if (state_r == ST_EXEC) begin
                key_opcode <= opc_r;
                key_seq <= seq_r;
                key_instr <= ent.instr;
                key_ctx_present <= ent.ctx_mode;
                if (ent.ctx_mode) begin
                    key_ctx_tag <= CTX_W'(pay_r >> sh);
                    key_data <= KEY_W'(pay_r & kmask);
                end else begin
                    key_ctx_tag <= '0;
                    key_data <= KEY_W'(pay_r);
                end
            end
        end
    end

    // direct write delivery
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dw_valid <= 1'b0;
            dw_target <= TGT_REG;
            dw_fmt <= 1'b0;
            dw_entry_valid <= 1'b0;
            dw_loc <= 23'h000000;
            dw_data <= '0;
            dw_mask <= '0;
        end else begin
            dw_valid <= (state_r == ST_EXEC) && opc_r == OPC_DIR_WR && !dw_err;
            if (state_r == ST_EXEC) begin
                dw_target <= daddr.target;
                dw_fmt <= daddr.write_format_sel;
                dw_entry_valid <= daddr.entry_valid_bit;
                dw_loc <= daddr.loc;
                unique case (daddr.target)
                    TGT_ASSOC: begin
                        dw_data <= pay_r[DATA_W +: DATA_W]
                                   & ~({DATA_W{1'b1}} << (daddr.write_format_sel
                                       ? ASSOC_WIDE : ASSOC_NARROW));
                        dw_mask <= '0;
                    end
                    TGT_RULE_DB: begin
                        dw_data <= pay_r[DATA_W +: DATA_W];
                        dw_mask <= pay_r[DATA_W-1:0];
                    end
                    default: begin
                        dw_data <= pay_r[DATA_W +: DATA_W];
                        dw_mask <= '0;
                    end
                endcase
            end
        end
    end
endmodule : rtdad_device

/* core/rtdad_host.sv */
// host end: serialises request records and parses status responses
`timescale 1ns/100ps
module rtdad_host
    import rtdad_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    rtdad_link_if.hst link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [7:0] cmd_opcode,
    input wire logic [6:0] cmd_len,
    input wire logic [PAY_W-1:0] cmd_payload,
    output logic [15:0] cmd_seq,
    output logic rsp_valid,
    output logic [7:0] rsp_opcode,
    output logic [15:0] rsp_seq,
    output logic [7:0] rsp_status,
    output logic [18:0] rsp_entry
);
    logic [TX_W-1:0] tx_r;
    logic [6:0] txcnt_r;
    logic [15:0] seq_r;
    logic wait_tw_r;
    logic [6:0] rxidx_r;
    logic [31:0] rxpay_r;
    logic [7:0] rxopc_r;
    logic [15:0] rxseq_r;
    logic [6:0] rxlast;
    logic take;
    logic rx_done;
    logic [PAY_W-1:0] fixed;
    rtdad_addr_s a;

    assign cmd_ready = (txcnt_r == 7'h00) && !wait_tw_r;
    assign take = cmd_valid && cmd_ready;
    assign cmd_seq = seq_r;
    assign link.req_valid = (txcnt_r != 7'h00);
    assign link.req_data = tx_r[TX_W-1 -: 8];
    assign link.rsp_ready = 1'b1;
    assign rxlast = LEN_HDR + ((rxopc_r == OPC_TBL_RD) ? LEN_RD_RSP : LEN_STS_RSP) - 7'h01;
    assign rx_done = link.rsp_valid && rxidx_r != 7'h00 && rxidx_r == rxlast;

    // direct write address cleaned of illegal format and valid bits
    always_comb begin
        fixed = cmd_payload;
        a = cmd_payload[DW_ADDR_LSB +: 32];
        if (cmd_opcode == OPC_DIR_WR) begin
            if (a.target == TGT_REG) begin
                a.write_format_sel = 1'b0;
            end
            if (a.target != TGT_RULE_DB) begin
                a.entry_valid_bit = 1'b0;
            end
            fixed[DW_ADDR_LSB +: 32] = a;
        end
    end

    // transmit shifter, payload sent most significant byte first
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_r <= '0;
            txcnt_r <= 7'h00;
            seq_r <= 16'h0000;
        end else if (take) begin
            tx_r <= {cmd_opcode, seq_r, fixed << {LEN_PAY_MAX - cmd_len, 3'b000}};
            txcnt_r <= cmd_len + LEN_HDR;
            seq_r <= seq_r + 16'h0001;
        end else if (link.req_valid && link.req_ready) begin
            tx_r <= {tx_r[TX_W-9:0], 8'h00};
            txcnt_r <= txcnt_r - 7'h01;
        end
    end

    // hold new commands until the table write is answered
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_tw_r <= 1'b0;
        end else if (take && cmd_opcode == OPC_TBL_WR) begin
            wait_tw_r <= 1'b1;
        end else if (rx_done && rxopc_r == OPC_TBL_WR) begin
            wait_tw_r <= 1'b0;
        end
    end

    // response parser
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxidx_r <= 7'h00;
            rxpay_r <= 32'h00000000;
            rxopc_r <= 8'h00;
            rxseq_r <= 16'h0000;
        end else if (link.rsp_valid) begin
            if (rxidx_r == 7'h00) begin
                rxopc_r <= link.rsp_data;
            end else if (rxidx_r < LEN_HDR) begin
                rxseq_r <= {rxseq_r[7:0], link.rsp_data};
            end
            rxpay_r <= {rxpay_r[23:0], link.rsp_data};
            rxidx_r <= rx_done ? 7'h00 : rxidx_r + 7'h01;
        end
    end

    // completed response report
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_opcode <= 8'h00;
            rsp_seq <= 16'h0000;
            rsp_status <= 8'h00;
            rsp_entry <= 19'h00000;
        end else begin
            rsp_valid <= rx_done;
            if (rx_done) begin
                rsp_opcode <= rxopc_r;
                rsp_seq <= rxseq_r;
                if (rxopc_r == OPC_TBL_RD) begin
                    rsp_status <= rxpay_r[23:16];
                    rsp_entry <= {rxpay_r[10:0], link.rsp_data};
                end else begin
                    rsp_status <= link.rsp_data;
                    rsp_entry <= 19'h00000;
                end
            end
        end
    end
endmodule : rtdad_host

/* testbench/rtdad_link_props.sv */
// link checker: request framing and response record shape
`timescale 1ns/100ps
module rtdad_link_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic [7:0] req_data,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_ready
);
    logic [2:0] idx_r;
    logic [7:0] op_r;
    logic [7:0] sh_r;
    logic [7:0] sl_r;
    logic [7:0] pb1_r;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // byte position inside the current request, padding skipped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idx_r <= 3'h0;
        end else if (!req_ready) begin
            idx_r <= 3'h0;
        end else if (req_valid && idx_r != 3'h5 && (idx_r != 3'h0 || req_data != 8'h00)) begin
            idx_r <= idx_r + 3'h1;
        end
    end
    // keep opcode, sequence and second payload byte
    always_ff @(posedge clk) begin
        if (req_valid && req_ready) begin
            case (idx_r)
                3'h0: op_r <= req_data;
                3'h1: sh_r <= req_data;
                3'h2: sl_r <= req_data;
                3'h4: pb1_r <= req_data;
                default: ;
            endcase
        end
    end
    sequence s_hdr;
        rsp_data == op_r ##1 rsp_data == sh_r ##1 rsp_data == sl_r;
    endsequence
    sequence s_rd_tail;
        rsp_data == 8'h00 ##1 rsp_data[7:3] == 5'h00;
    endsequence
    property p_hdr_echo;
        $rose(rsp_valid) |-> s_hdr;
    endproperty
    property p_sts_len;
        $rose(rsp_valid) && rsp_data != 8'hfe |-> rsp_valid [*4] ##1 !rsp_valid;
    endproperty
    property p_rd_len;
        $rose(rsp_valid) && rsp_data == 8'hfe |-> rsp_valid [*7] ##1 !rsp_valid;
    endproperty
    property p_sts_zero;
        $rose(rsp_valid) |-> ##3 rsp_data[7:1] == 7'h00;
    endproperty
    property p_rd_pad;
        $rose(rsp_valid) && op_r == 8'hfe |-> ##3 s_rd_tail;
    endproperty
    property p_tw_bad;
        $rose(rsp_valid) && op_r == 8'hff && pb1_r[7:3] != 5'h00 |-> ##3 rsp_data == 8'h01;
    endproperty
    property p_rsp_follows;
        $fell(req_ready) && op_r inside {8'hfd, 8'hfe, 8'hff} |=> rsp_valid;
    endproperty
    property p_inv_sts;
        $rose(rsp_valid) && !(op_r inside {8'hfd, 8'hfe, 8'hff}) |-> ##3 rsp_data == 8'h01;
    endproperty
    property p_busy_rsp;
        rsp_valid |-> !req_ready;
    endproperty
    property p_reset_idle;
        $fell(rst) |-> !rsp_valid && req_ready;
    endproperty
    a_hdr_echo: assert property (p_hdr_echo)
        else $error("response header differs from request");
    a_sts_len: assert property (p_sts_len)
        else $error("status response length wrong");
    a_rd_len: assert property (p_rd_len)
        else $error("table read response length wrong");
    a_sts_zero: assert property (p_sts_zero)
        else $error("status upper bits not zero");
    a_rd_pad: assert property (p_rd_pad)
        else $error("table read status or pad bits wrong");
    a_tw_bad: assert property (p_tw_bad)
        else $error("bad table write not flagged");
    a_rsp_follows: assert property (p_rsp_follows)
        else $error("response not started after exec");
    a_inv_sts: assert property (p_inv_sts)
        else $error("invalid entry record not flagged");
    a_busy_rsp: assert property (p_busy_rsp)
        else $error("request taken while responding");
    a_reset_idle: assert property (p_reset_idle)
        else $error("link not idle after reset");
endmodule : rtdad_link_props

/* testbench/tb.sv */
// bench: host and device ends joined over the record link
`timescale 1ns/100ps
module tb;
    import rtdad_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic [7:0] cmd_opcode = 8'h00;
    logic [6:0] cmd_len = 7'h00;
    logic [PAY_W-1:0] cmd_payload = '0;
    logic cmd_ready, rsp_valid, key_valid, key_ctx_present, dw_valid, dw_fmt, dw_entry_valid;
    logic [15:0] cmd_seq, rsp_seq, key_seq;
    logic [7:0] rsp_opcode, rsp_status, key_opcode;
    logic [18:0] rsp_entry;
    logic [9:0] key_instr;
    logic [CTX_W-1:0] key_ctx_tag;
    logic [KEY_W-1:0] key_data;
    rtdad_target_e dw_target;
    logic [22:0] dw_loc;
    logic [DATA_W-1:0] dw_data, dw_mask;
    logic [15:0] seq_n = 16'h0000;
    logic [50:0] rsp_q[$];
    logic [690:0] key_q[$];
    logic [186:0] dw_q[$];
    logic [18:0] ents[4];
    int miscompares = 0;
    int checked = 0;
    int cyc = 0;
    rtdad_link_if lnk ();
    rtdad_host u_rtdad_host (.clk(clk), .rst(rst), .link(lnk), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode), .cmd_len(cmd_len),
        .cmd_payload(cmd_payload), .cmd_seq(cmd_seq), .rsp_valid(rsp_valid),
        .rsp_opcode(rsp_opcode), .rsp_seq(rsp_seq), .rsp_status(rsp_status), .rsp_entry(rsp_entry));
    rtdad_device u_rtdad_device (.clk(clk), .rst(rst), .link(lnk), .key_valid(key_valid),
        .key_opcode(key_opcode), .key_seq(key_seq), .key_instr(key_instr),
        .key_ctx_present(key_ctx_present), .key_ctx_tag(key_ctx_tag), .key_data(key_data),
        .dw_valid(dw_valid), .dw_target(dw_target), .dw_fmt(dw_fmt),
        .dw_entry_valid(dw_entry_valid), .dw_loc(dw_loc), .dw_data(dw_data), .dw_mask(dw_mask));
    rtdad_link_props u_rtdad_link_props (.clk(clk), .rst(rst), .req_valid(lnk.req_valid),
        .req_data(lnk.req_data), .req_ready(lnk.req_ready), .rsp_valid(lnk.rsp_valid),
        .rsp_data(lnk.rsp_data), .rsp_ready(lnk.rsp_ready));
    // free-running clock
    always #12.5 clk = ~clk;
    task automatic end_of_test();
        miscompares += rsp_q.size() + key_q.size() + dw_q.size();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test
    task automatic report(input logic [690:0] got, input logic [690:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : report
    task automatic cmp_rsp(input logic [50:0] got, input logic [50:0] exp);
        report(got, exp);
    endtask : cmp_rsp
    task automatic cmp_key(input logic [690:0] got, input logic [690:0] exp);
        report(got, exp);
    endtask : cmp_key
    task automatic cmp_dw(input logic [186:0] got, input logic [186:0] exp);
        report(got, exp);
    endtask : cmp_dw
    // results against oldest note, plus run ceiling
    always @(posedge clk) begin
        cyc++;
        if (rsp_valid === 1'b1) cmp_rsp({rsp_opcode, rsp_seq, rsp_status,
            (rsp_opcode == OPC_TBL_RD) ? rsp_entry : 19'h0}, rsp_q.pop_front());
        if (key_valid === 1'b1) cmp_key({key_opcode, key_seq, key_instr, key_ctx_present,
            key_ctx_present ? key_ctx_tag : 16'h0, key_data}, key_q.pop_front());
        if (dw_valid === 1'b1) cmp_dw({dw_target, dw_fmt, dw_entry_valid, dw_loc, dw_data,
            dw_mask}, dw_q.pop_front());
        if (cyc == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic wire_byte(input logic [7:0] exp);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!(lnk.req_valid === 1'b1 && lnk.req_ready === 1'b1) && n < 200);
        report(lnk.req_data, exp);
    endtask : wire_byte
    task automatic send(input logic [7:0] op, input logic [6:0] len, input logic [PAY_W-1:0] pay);
        int n;
        logic [23:0] hdr;
        hdr = {op, seq_n};
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_opcode = op;
        cmd_len = len;
        cmd_payload = pay;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 2000);
        report(cmd_seq, seq_n);
        seq_n++;
        @(negedge clk);
        cmd_valid = 1'b0;
        for (int i = 0; i < 3; i++) wire_byte(hdr[23 - 8 * i -: 8]);
    endtask : send
    task automatic tbl_wr(input logic [7:0] a, input logic [18:0] e, input logic [4:0] z);
        rsp_q.push_back({OPC_TBL_WR, seq_n, 7'h00, z != 5'h00, 19'h0});
        send(OPC_TBL_WR, LEN_TBL_WR, {a, z, e});
    endtask : tbl_wr
    task automatic tbl_rd(input logic [7:0] a, input logic [18:0] e);
        rsp_q.push_back({OPC_TBL_RD, seq_n, 8'h00, e});
        send(OPC_TBL_RD, LEN_TBL_RD, a);
    endtask : tbl_rd
    task automatic key_rec(input logic [7:0] op, input logic [18:0] e);
        logic [PAY_W-1:0] p;
        logic [PAY_W-1:0] k;
        int b;
        for (int i = 0; i < PAY_W / 16; i++) p[i * 16 +: 16] = 16'($urandom);
        b = e[6:0] * 8;
        p = p & ~({PAY_W{1'b1}} << b);
        k = e[8] ? p & ~({PAY_W{1'b1}} << (b - 16)) : p;
        if (e[7] !== 1'b1) rsp_q.push_back({op, seq_n, 8'h01, 19'h0});
        else key_q.push_back({op, seq_n, e[18:9], e[8],
            e[8] ? 16'(p >> (b - 16)) : 16'h0, k[KEY_W-1:0]});
        send(op, e[6:0], p);
    endtask : key_rec
    task automatic dir_wr(input logic [31:0] a);
        logic [DATA_W-1:0] d;
        logic [DATA_W-1:0] m;
        logic [1:0] t;
        logic bad;
        d = {16'($urandom), $urandom, $urandom};
        m = {16'($urandom), $urandom, $urandom};
        t = a[26:25];
        bad = a[29:27] != 3'h0 || a[24:23] != 2'h0 || t == 2'b11;
        rsp_q.push_back({OPC_DIR_WR, seq_n, 7'h00, bad, 19'h0});
        if (!bad) dw_q.push_back({t, a[31] && t != 2'b00, a[30] && t == 2'b01, a[22:0],
            (t != 2'b10) ? d : (a[31] ? {16'h0, d[63:0]} : {48'h0, d[31:0]}),
            (t == 2'b01) ? m : 80'h0});
        send(OPC_DIR_WR, LEN_DIR_WR, {a, d, m});
    endtask : dir_wr
    task automatic wait_idle();
        for (int n = 0; n < 500 && rsp_q.size() + key_q.size() + dw_q.size() != 0; n++)
            @(posedge clk);
    endtask : wait_idle
    // main sequence
    initial begin
        logic [31:0] a;
        void'($urandom(32'h4bd4));
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        tbl_rd(8'h10, 19'h0);
        key_rec(8'h10, 19'h0);
        for (int i = 0; i < 4; i++) begin
            ents[i] = {(i[1] ? 3'($urandom) : 3'h1), 7'($urandom), i[1], 1'b1,
                7'(i[0] ? (i[1] ? 82 : 80) : (i[1] ? 3 : 1))};
            tbl_wr(8'(16 + i), ents[i], 5'h00);
            tbl_rd(8'(16 + i), ents[i]);
            key_rec(8'(16 + i), ents[i]);
            key_rec(8'(16 + i), ents[i]);
        end
        tbl_wr(8'h10, 19'h0, 5'(1 + $urandom % 31));
        tbl_rd(8'h10, ents[0]);
        for (int k = 0; k < 7; k++) begin
            a = $urandom;
            a[29:23] = {3'h0, 2'(k), (k == 4) ? 2'h1 : 2'h0};
            if (k == 5) a[28] = 1'b1;
            if (k == 2 || k == 6) a[31] = k[2];
            dir_wr(a);
        end
        wait_idle();
        @(negedge clk);
        rst = 1'b1;
        seq_n = 16'h0000;
        @(negedge clk);
        rst = 1'b0;
        tbl_rd(8'h11, 19'h0);
        key_rec(8'h11, 19'h0);
        wait_idle();
        end_of_test();
    end
endmodule : tb
